// [logic/adc_conversion_control.sv]
`timescale 1ns/1ps
module adc_conversion_control
   import adc_ctrl_pkg::*;
(
   input wire logic aclk,                     // System clock
   input wire logic aresetn,                  // Synchronous reset, active low
   input wire logic [ADDR_W-1:0] awaddr,      // Write address
   input wire logic awvalid,                  // Write address valid
   output logic awready,                      // Write address ready
   input wire logic [DATA_W-1:0] wdata,       // Write data
   input wire logic [3:0] wstrb,              // Write byte strobes
   input wire logic wvalid,                   // Write data valid
   output logic wready,                       // Write data ready
   output logic [1:0] bresp,                  // Write response
   output logic bvalid,                       // Write response valid
   input wire logic bready,                   // Write response ready
   input wire logic [ADDR_W-1:0] araddr,      // Read address
   input wire logic arvalid,                  // Read address valid
   output logic arready,                      // Read address ready
   output logic [DATA_W-1:0] rdata,           // Read data
   output logic [1:0] rresp,                  // Read response
   output logic rvalid,                       // Read data valid
   input wire logic rready,                   // Read data ready
   input wire logic hardware_trigger_in,      // Hardware conversion trigger
   input wire logic conv_done,                // Converter finished, one cycle
   input wire logic [RES_W-1:0] conv_data,    // Converter raw result
   output logic conv_start,                   // Start a conversion, one cycle
   output logic conv_abort,                   // Abort running conversion
   output logic [CH_W-1:0] conv_channel,      // Selected channel code
   output logic sel_vrefh,                    // High reference selected
   output logic sel_vrefl,                    // Low reference selected
   output logic conv_power_on,                // Converter powered
   output logic conv_isolate,                 // Input isolated from all sources
   output logic conv_low_power,               // Converter idle in low power
   output logic irq                           // Interrupt, level
);

   typedef enum {S_IDLE, S_BUSY} seq_state_t;

   seq_state_t state;
   seq_state_t next_state;
   logic conversion_complete_flag;
   logic conversion_irq_enable;
   logic continuous_enable;
   logic [CH_W-1:0] channel_select;
   logic trigger_select;
   logic compare_enable;
   logic compare_greater_equal;
   res_mode_t mode;
   logic [RES_W-1:0] cmp_value;
   logic [RES_W-1:0] result;
   logic [IRQ_N-1:0] irq_status;
   logic [IRQ_N-1:0] irq_enable;
   logic [IRQ_N-1:0] irq_event;
   logic pend_start;
   logic run;
   logic hw_prev;
   logic wr_fire;
   logic rd_fire;
   logic csc_wr;
   logic res_lo_rd;
   logic [CH_W-1:0] new_ch;
   logic sw_go;
   logic hw_go;
   logic repeat_go;
   logic start_now;
   logic done_ok;
   logic flag_set;
   logic [RES_W-1:0] shaped;
   logic cmp_true;

   // ------------------------------------------------------------
   // Decoding helpers
   // ------------------------------------------------------------
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      is_mapped = (a == OFF_CSC) || (a == OFF_CTRL2) || (a == OFF_RES_LO) ||
                  (a == OFF_RES_HI) || (a == OFF_CMP) || (a == OFF_CFG) ||
                  (a == OFF_IRQ_STAT) || (a == OFF_IRQ_CLR) || (a == OFF_IRQ_EN);
   endfunction

   function automatic chan_kind_t chan_kind(input logic [CH_W-1:0] ch);
      if (ch <= CH_LAST_INPUT)
         chan_kind = K_INPUT;
      else if (ch == CH_RESERVED)
         chan_kind = K_RESERVED;
      else if (ch == CH_VREFH)
         chan_kind = K_VREFH;
      else if (ch == CH_VREFL)
         chan_kind = K_VREFL;
      else
         chan_kind = K_OFF;
   endfunction

   // ------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------
   // Address and data are taken together; the master holds both until then
   assign awready = awvalid && wvalid && !bvalid;
   assign wready = awready;
   assign arready = !rvalid;
   assign wr_fire = awvalid && wvalid && awready;
   assign rd_fire = arvalid && arready;
   assign csc_wr = wr_fire && (awaddr == OFF_CSC) && wstrb[0];
   assign res_lo_rd = rd_fire && (araddr == OFF_RES_LO);
   assign new_ch = wdata[CH_W-1:0];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid <= 1'b1;
         bresp <= is_mapped(awaddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
         bvalid <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid <= 1'b0;
         rresp <= RESP_OKAY;
         rdata <= '0;
      end
      else if (rd_fire)
      begin
         rvalid <= 1'b1;
         rresp <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
         unique case (araddr)
            OFF_CSC: rdata <= DATA_W'({conversion_complete_flag, conversion_irq_enable,
                                      continuous_enable, channel_select});
            OFF_CTRL2: rdata <= DATA_W'({state == S_BUSY, trigger_select, compare_enable,
                                        compare_greater_equal, 4'h0});
            OFF_RES_LO: rdata <= DATA_W'(result[7:0]);
            OFF_RES_HI: rdata <= DATA_W'(result[RES_W-1:8]);
            OFF_CMP: rdata <= DATA_W'(cmp_value);
            OFF_CFG: rdata <= DATA_W'(mode);
            OFF_IRQ_STAT: rdata <= DATA_W'(irq_status);
            OFF_IRQ_EN: rdata <= DATA_W'(irq_enable);
            default: rdata <= '0;
         endcase
      end
      else if (rready)
         rvalid <= 1'b0;
   end

   // ------------------------------------------------------------
   // Software-written configuration
   // ------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         conversion_irq_enable <= 1'b0;
         continuous_enable <= 1'b0;
         channel_select <= CH_RESET;
      end
      else if (csc_wr)
      begin
         conversion_irq_enable <= wdata[CSC_IEN_BIT];
         continuous_enable <= wdata[CSC_CONT_BIT];
         channel_select <= new_ch;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         trigger_select <= 1'b0;
         compare_enable <= 1'b0;
         compare_greater_equal <= 1'b0;
         mode <= MODE_RESET;
         cmp_value <= '0;
         irq_enable <= '0;
      end
      else if (wr_fire)
      begin
         if (awaddr == OFF_CTRL2 && wstrb[0])
         begin
            trigger_select <= wdata[CTRL2_TRIG_BIT];
            compare_enable <= wdata[CTRL2_CMPEN_BIT];
            compare_greater_equal <= wdata[CTRL2_CMPGE_BIT];
         end
         // The unused fourth code is refused so the format never goes undefined
         if (awaddr == OFF_CFG && wstrb[0] && wdata[MODE_W-1:0] != 2'h3)
            mode <= res_mode_t'(wdata[MODE_W-1:0]);
         if (awaddr == OFF_CMP && wstrb[0])
            cmp_value[7:0] <= wdata[7:0];
         if (awaddr == OFF_CMP && wstrb[1])
            cmp_value[RES_W-1:8] <= wdata[RES_W-1:8];
         if (awaddr == OFF_IRQ_EN && wstrb[0])
            irq_enable <= wdata[IRQ_N-1:0];
      end
   end

   // ------------------------------------------------------------
   // Conversion sequencer
   // ------------------------------------------------------------
   assign sw_go = csc_wr && (new_ch != CH_OFF) && !trigger_select;
   assign hw_go = trigger_select && hardware_trigger_in && !hw_prev && !csc_wr &&
                  (chan_kind(channel_select) != K_OFF) && (state == S_IDLE) &&
                  !pend_start;
   // A CSC write in the same cycle as completion wins: that result is dropped
   assign done_ok = conv_done && (state == S_BUSY) && !csc_wr;
   assign repeat_go = done_ok && continuous_enable && run &&
                      (chan_kind(channel_select) != K_OFF);
   assign start_now = pend_start || hw_go || repeat_go;

   always_comb
   begin
      next_state = state;
      if (csc_wr)
         next_state = S_IDLE;
      else if (start_now)
         next_state = S_BUSY;
      else if (done_ok)
         next_state = S_IDLE;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= S_IDLE;
         pend_start <= 1'b0;
         conv_start <= 1'b0;
         conv_abort <= 1'b0;
         hw_prev <= 1'b0;
         conv_low_power <= 1'b1;
      end
      else
      begin
         state <= next_state;
         pend_start <= sw_go;
         conv_start <= start_now;
         conv_abort <= csc_wr && (state == S_BUSY);
         hw_prev <= hardware_trigger_in;
         conv_low_power <= (next_state == S_IDLE) && !sw_go;
      end
   end

   // Run marks an active continuous sequence; hardware mode arms on the first event
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         run <= 1'b0;
      else if (csc_wr)
         run <= wdata[CSC_CONT_BIT] && (new_ch != CH_OFF) && !trigger_select;
      else if (hw_go)
         run <= continuous_enable;
      else if (done_ok && !continuous_enable)
         run <= 1'b0;
   end

   // ------------------------------------------------------------
   // Channel routing and power
   // ------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         conv_channel <= CH_RESET;
         sel_vrefh <= 1'b0;
         sel_vrefl <= 1'b0;
         conv_power_on <= 1'b0;
         conv_isolate <= 1'b1;
      end
      else
      begin
         conv_channel <= channel_select;
         sel_vrefh <= chan_kind(channel_select) == K_VREFH;
         sel_vrefl <= chan_kind(channel_select) == K_VREFL;
         conv_power_on <= chan_kind(channel_select) != K_OFF;
         conv_isolate <= chan_kind(channel_select) == K_OFF;
      end
   end

   // ------------------------------------------------------------
   // Result, completion flag and interrupts
   // ------------------------------------------------------------
   result_shaper u_shaper (
      .raw(conv_data),
      .mode(mode),
      .cmp_value(cmp_value),
      .cmp_ge(compare_greater_equal),
      .shaped(shaped),
      .cmp_true(cmp_true)
   );

   assign flag_set = done_ok && (!compare_enable || cmp_true);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         result <= '0;
      else if (flag_set)
         result <= shaped;
   end

   // Completion beats a result-low read clear in the same cycle; a CSC write drops the completion
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         conversion_complete_flag <= 1'b0;
      else if (flag_set)
         conversion_complete_flag <= 1'b1;
      else if (csc_wr || res_lo_rd)
         conversion_complete_flag <= 1'b0;
   end

   assign irq_event[EV_DONE] = flag_set && conversion_irq_enable;
   assign irq_event[EV_ABORT] = csc_wr && (state == S_BUSY);

   generate
      for (genvar i = 0; i < IRQ_N; i++)
      begin : g_irq
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
               irq_status[i] <= 1'b0;
            else if (irq_event[i])
               irq_status[i] <= 1'b1;
            else if (wr_fire && awaddr == OFF_IRQ_CLR && wstrb[0] && wdata[i])
               irq_status[i] <= 1'b0;
         end
      end
   endgenerate

   assign irq = |(irq_status & irq_enable);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_write_restart;
      csc_wr && (new_ch != CH_OFF) && !trigger_select;
   endsequence

   sequence s_start_issued;
      pend_start ##1 conv_start;
   endsequence

   property p_write_restart;
      @(posedge aclk) disable iff (!aresetn)
      s_write_restart |=> s_start_issued;
   endproperty
   a_write_restart: assert property (p_write_restart)
      else $error("write did not restart a conversion two cycles later");

   property p_off_no_start;
      @(posedge aclk) disable iff (!aresetn)
      (channel_select == CH_OFF) && !csc_wr ##1 (channel_select == CH_OFF)
         |=> !conv_start && conv_isolate;
   endproperty
   a_off_no_start: assert property (p_off_no_start)
      else $error("converter started or was connected while switched off");

   property p_flag_set;
      @(posedge aclk) disable iff (!aresetn)
      done_ok && !compare_enable |=> conversion_complete_flag && result == $past(shaped);
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("completion flag or result not updated after a conversion");

   property p_compare_miss;
      @(posedge aclk) disable iff (!aresetn)
      done_ok && compare_enable && !cmp_true && !res_lo_rd |=> $stable(conversion_complete_flag)
         && $stable(result);
   endproperty
   a_compare_miss: assert property (p_compare_miss)
      else $error("flag or result changed on a failed compare");

   property p_compare_ge;
      @(posedge aclk) disable iff (!aresetn)
      done_ok && compare_enable && compare_greater_equal && (shaped >= cmp_value) &&
         (mode == MODE_12) |=> conversion_complete_flag;
   endproperty
   a_compare_ge: assert property (p_compare_ge)
      else $error("greater-or-equal compare did not set the flag");

   property p_flag_clear;
      @(posedge aclk) disable iff (!aresetn)
      (csc_wr || res_lo_rd) && !flag_set |=> !conversion_complete_flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("completion flag survived a clearing access");

   property p_irq_raise;
      @(posedge aclk) disable iff (!aresetn)
      flag_set && conversion_irq_enable && irq_enable[EV_DONE] |=> irq [*2];
   endproperty
   a_irq_raise: assert property (p_irq_raise)
      else $error("interrupt not raised after an enabled completion");

   property p_single_idle;
      @(posedge aclk) disable iff (!aresetn)
      done_ok && !continuous_enable && !hw_go |=> state == S_IDLE && !conv_start;
   endproperty
   a_single_idle: assert property (p_single_idle)
      else $error("single mode kept converting after completion");

   property p_low_power;
      @(posedge aclk) disable iff (!aresetn)
      done_ok && !continuous_enable && !hw_go |=> conv_low_power;
   endproperty
   a_low_power: assert property (p_low_power)
      else $error("low power not entered after a single conversion");

   property p_continuous;
      @(posedge aclk) disable iff (!aresetn)
      repeat_go |=> conv_start && state == S_BUSY;
   endproperty
   a_continuous: assert property (p_continuous)
      else $error("continuous mode did not start the next conversion");

   property p_format;
      @(posedge aclk) disable iff (!aresetn)
      flag_set && mode == MODE_8 |=> result[RES_W-1:8] == 4'h0;
   endproperty
   a_format: assert property (p_format)
      else $error("8-bit result not right-justified");

endmodule // adc_conversion_control

// [logic/adc_ctrl_pkg.sv]
package adc_ctrl_pkg;

   // ------------------------------------------------------------
   // Bus and register map
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] OFF_CSC = 8'h00;
   localparam logic [7:0] OFF_CTRL2 = 8'h04;
   localparam logic [7:0] OFF_RES_LO = 8'h08;
   localparam logic [7:0] OFF_RES_HI = 8'h0C;
   localparam logic [7:0] OFF_CMP = 8'h10;
   localparam logic [7:0] OFF_CFG = 8'h14;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
   localparam logic [7:0] OFF_IRQ_CLR = 8'h1C;
   localparam logic [7:0] OFF_IRQ_EN = 8'h20;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // Status and control field layout
   // ------------------------------------------------------------
   localparam int CSC_FLAG_BIT = 7;
   localparam int CSC_IEN_BIT = 6;
   localparam int CSC_CONT_BIT = 5;
   localparam int CH_W = 5;
   localparam logic [4:0] CH_LAST_INPUT = 5'h1B;
   localparam logic [4:0] CH_RESERVED = 5'h1C;
   localparam logic [4:0] CH_VREFH = 5'h1D;
   localparam logic [4:0] CH_VREFL = 5'h1E;
   localparam logic [4:0] CH_OFF = 5'h1F;
   localparam logic [4:0] TEMP_SENSOR_CHANNEL = 5'h1A;
   localparam logic [4:0] BANDGAP_CHANNEL = 5'h1B;
   localparam logic [4:0] CH_RESET = 5'h1F;
   localparam int CTRL2_ACTIVE_BIT = 7;
   localparam int CTRL2_TRIG_BIT = 6;
   localparam int CTRL2_CMPEN_BIT = 5;
   localparam int CTRL2_CMPGE_BIT = 4;

   // ------------------------------------------------------------
   // Result formats and interrupt events
   // ------------------------------------------------------------
   localparam int RES_W = 12;
   localparam int MODE_W = 2;
   typedef enum logic [1:0] {MODE_8 = 2'h0, MODE_12 = 2'h1, MODE_10 = 2'h2} res_mode_t;
   localparam res_mode_t MODE_RESET = MODE_8;
   localparam int IRQ_N = 2;
   localparam int EV_DONE = 0;
   localparam int EV_ABORT = 1;
   typedef enum {K_INPUT, K_RESERVED, K_VREFH, K_VREFL, K_OFF} chan_kind_t;

endpackage

// [logic/result_shaper.sv]
`timescale 1ns/1ps
module result_shaper
   import adc_ctrl_pkg::*;
(
   input wire logic [RES_W-1:0] raw,         // Raw 12-bit converter output
   input wire res_mode_t mode,               // Selected result format
   input wire logic [RES_W-1:0] cmp_value,   // Programmed compare value
   input wire logic cmp_ge,                  // Compare direction
   output logic [RES_W-1:0] shaped,          // Right-justified result
   output logic cmp_true                     // Compare condition
);

   logic [RES_W-1:0] cmp_masked;

   always_comb
   begin
      unique case (mode)
         MODE_12:
         begin
            shaped = raw;
            cmp_masked = cmp_value;
         end
         MODE_10:
         begin
            shaped = {2'h0, raw[RES_W-1:2]};
            cmp_masked = {2'h0, cmp_value[9:0]};
         end
         default:
         begin
            shaped = {4'h0, raw[RES_W-1:4]};
            cmp_masked = {4'h0, cmp_value[7:0]};
         end
      endcase
   end

   // Compare uses only the bits that the current format carries
   assign cmp_true = cmp_ge ? (shaped >= cmp_masked) : (shaped < cmp_masked);

endmodule // result_shaper

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench;
   import adc_ctrl_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, hardware_trigger_in, conv_done;
   logic awready, wready, bvalid, arready, rvalid, conv_start, conv_abort, irq;
   logic sel_vrefh, sel_vrefl, conv_power_on, conv_isolate, conv_low_power, ge;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata, rd, hi;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   logic [RES_W-1:0] conv_data, raw, cmpv;
   logic [CH_W-1:0] conv_channel, ch;
   int n_mismatch, cmp_count, n_start, n_done, n_abort, lat, s, i, k;
   res_mode_t md;
   adc_conversion_control u_adc_conversion_control (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .hardware_trigger_in(hardware_trigger_in),
      .conv_done(conv_done), .conv_data(conv_data), .conv_start(conv_start),
      .conv_abort(conv_abort), .conv_channel(conv_channel), .sel_vrefh(sel_vrefh),
      .sel_vrefl(sel_vrefl), .conv_power_on(conv_power_on), .conv_isolate(conv_isolate),
      .conv_low_power(conv_low_power), .irq(irq));
   // ------------------------------------------------------------
   // Converter stand-in: random latency, data toggles outside the done pulse
   // ------------------------------------------------------------
   always @(posedge aclk)
   begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_start === 1'b1)
         lat <= 2 + $urandom % 8;
      else if (conv_abort === 1'b1)
         lat <= 0;
      else if (lat > 1)
         lat <= lat - 1;
      else if (lat == 1)
      begin
         lat <= 0;
         raw = RES_W'($urandom % 4096);
         conv_data <= raw;
         conv_done <= 1'b1;
         n_done++;
      end
      if (conv_start === 1'b1)
         n_start++;
      if (conv_abort === 1'b1)
         n_abort++;
   end
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // ------------------------------------------------------------
   // Bus tasks and expectations
   // ------------------------------------------------------------
   task automatic wrap_up();
      if (n_mismatch == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One idle edge first, so a strobe dropped by the last transfer never meets a new one
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int t;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (t = 0; t < 100; t++)
      begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid && bready)
         begin
            resp = bresp;
            bready <= 1'b0;
            return;
         end
      end
      n_mismatch++;
      wrap_up();
   endtask
   task automatic rdr(input logic [7:0] a);
      int t;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (t = 0; t < 100; t++)
      begin
         @(posedge aclk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid && rready)
         begin
            rd = rdata;
            resp = rresp;
            rready <= 1'b0;
            return;
         end
      end
      n_mismatch++;
      wrap_up();
   endtask
   task automatic wait_done();
      int t;
      int k0;
      k0 = n_done;
      for (t = 0; t < 300 && n_done == k0; t++)
         @(posedge aclk);
      if (n_done == k0)
      begin
         n_mismatch++;
         wrap_up();
      end
      else
         repeat (4) @(posedge aclk);
   endtask
   function automatic logic [31:0] fmt(input logic [11:0] v, input res_mode_t m);
      return (m == MODE_12) ? {20'h0, v} : (m == MODE_10) ? {22'h0, v[11:2]} : {24'h0, v[11:4]};
   endfunction
   function automatic logic [31:0] hit(input logic [11:0] v, input logic [11:0] c, input logic g,
                                       input res_mode_t m);
      logic [31:0] f;
      logic [11:0] cm;
      f = fmt(v, m);
      // Compare sees only the bits that the selected format carries
      cm = (m == MODE_12) ? c : (m == MODE_10) ? {2'h0, c[9:0]} : {4'h0, c[7:0]};
      return {31'h0, g ? (f[11:0] >= cm) : (f[11:0] < cm)};
   endfunction
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, hardware_trigger_in} = '0;
      {awaddr, araddr, wdata, conv_done, conv_data, lat} = '0;
      wstrb = 4'hF;
      void'($urandom(32'h940E));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rdr(OFF_CSC);
      chk("csc_reset", rd, 32'h1F);
      chk("isolate_reset", {31'h0, conv_isolate}, 32'h1);
      chk("power_reset", {31'h0, conv_power_on}, 32'h0);
      wr(OFF_IRQ_EN, 32'h1);
      for (i = 0; i < 3; i++)
      begin
         md = (i == 0) ? MODE_12 : (i == 1) ? MODE_10 : MODE_8;
         ch = CH_W'($urandom % 28);
         wr(OFF_CFG, {30'h0, md});
         s = n_start;
         wr(OFF_CSC, {24'h0, 3'b010, ch});
         wait_done();
         repeat (20) @(posedge aclk);
         chk("one_start", n_start - s, 32'h1);
         chk("low_power", {31'h0, conv_low_power}, 32'h1);
         chk("channel", {27'h0, conv_channel}, {27'h0, ch});
         chk("irq_on", {31'h0, irq}, 32'h1);
         rdr(OFF_CSC);
         chk("flag_set", rd, {24'h0, 3'b110, ch});
         rdr(OFF_RES_HI);
         hi = rd;
         rdr(OFF_RES_LO);
         chk("result", {hi[23:0], rd[7:0]}, fmt(raw, md));
         rdr(OFF_CSC);
         chk("flag_clr", rd, {24'h0, 3'b010, ch});
         wr(OFF_IRQ_CLR, 32'h1);
         chk("irq_clr", {31'h0, irq}, 32'h0);
      end
      wr(OFF_CSC, 32'h05);
      wait_done();
      chk("irq_masked", {31'h0, irq}, 32'h0);
      for (i = 0; i < 6; i++)
      begin
         // Pass 3 is a corner: a zero compare value always meets greater-or-equal
         md = (i % 3 == 0) ? MODE_12 : (i % 3 == 1) ? MODE_10 : MODE_8;
         cmpv = (i == 3) ? 12'h000 : RES_W'($urandom % 4096);
         ge = (i == 3) ? 1'b1 : 1'($urandom % 2);
         wr(OFF_CFG, {30'h0, md});
         wr(OFF_CMP, {20'h0, cmpv});
         wr(OFF_CTRL2, {26'h0, 1'b1, ge, 4'h0});
         wr(OFF_CSC, 32'h06);
         wait_done();
         rdr(OFF_CSC);
         chk("cmp_flag", {31'h0, rd[7]}, hit(raw, cmpv, ge, md));
      end
      wr(OFF_CTRL2, 32'h0);
      // Second write lands while the first conversion is still running
      s = n_start;
      k = n_abort;
      wr(OFF_CSC, 32'h07);
      wr(OFF_CSC, 32'h08);
      wait_done();
      chk("abort", n_abort - k, 32'h1);
      chk("restart", n_start - s, 32'h2);
      rdr(OFF_IRQ_STAT);
      chk("irq_stat", rd, 32'h2);
      chk("irq_mask", {31'h0, irq}, 32'h0);
      wr(OFF_IRQ_EN, 32'h3);
      chk("irq_abort", {31'h0, irq}, 32'h1);
      wr(OFF_IRQ_CLR, 32'h3);
      chk("irq_clr2", {31'h0, irq}, 32'h0);
      s = n_start;
      wr(OFF_CSC, 32'h29);
      repeat (80) @(posedge aclk);
      chk("continuous", {31'h0, (n_start - s) >= 4}, 32'h1);
      wr(OFF_CSC, 32'h3F);
      repeat (4) @(posedge aclk);
      s = n_start;
      repeat (40) @(posedge aclk);
      chk("no_extra", n_start - s, 32'h0);
      chk("power_off", {conv_power_on, conv_isolate}, 32'h1);
      for (i = 0; i < 2; i++)
      begin
         wr(OFF_CSC, (i == 0) ? 32'h1D : 32'h1E);
         wait_done();
         chk("vref", {sel_vrefh, sel_vrefl}, (i == 0) ? 32'h2 : 32'h1);
      end
      // Temperature reading order: bandgap first, then the sensor
      wr(OFF_CSC, {27'h0, BANDGAP_CHANNEL});
      wait_done();
      wr(OFF_CSC, {27'h0, TEMP_SENSOR_CHANNEL});
      wait_done();
      chk("temp_chan", {27'h0, conv_channel}, {27'h0, TEMP_SENSOR_CHANNEL});
      wr(OFF_CTRL2, 32'h40);
      s = n_start;
      wr(OFF_CSC, 32'h0A);
      repeat (10) @(posedge aclk);
      chk("hw_wait", n_start - s, 32'h0);
      hardware_trigger_in <= 1'b1;
      repeat (2) @(posedge aclk);
      hardware_trigger_in <= 1'b0;
      wait_done();
      repeat (20) @(posedge aclk);
      chk("hw_one", n_start - s, 32'h1);
      wr(8'h40, 32'h5);
      chk("wr_unmapped", {30'h0, resp}, {30'h0, RESP_SLVERR});
      rdr(8'h40);
      chk("rd_unmapped", {rd[29:0], resp}, {30'h0, RESP_SLVERR});
      wrap_up();
   end
endmodule // testbench
